// ===== logic/fsr_defines.svh
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

// ****************************************************
// opcodes
// ****************************************************
`define FSR_OP_READ_STATUS 8'h05
`define FSR_OP_READ_CONFIG 8'h15
`define FSR_OP_WRITE_ENABLE 8'h06
`define FSR_OP_WRITE_DISABLE 8'h04
`define FSR_OP_REG_WRITE 8'h01
`define FSR_OP_PAGE_PROG 8'h02
`define FSR_OP_QUAD_PROG 8'h38
`define FSR_OP_SECTOR_ERASE 8'h20
`define FSR_OP_HALF_BLOCK_ERASE 8'h52
`define FSR_OP_BLOCK_ERASE 8'hd8
`define FSR_OP_CHIP_ERASE 8'hc7
`define FSR_OP_ENTER_WIDE 8'hb7
`define FSR_OP_EXIT_WIDE 8'he9
`define FSR_OP_ENTER_QUAD 8'h35
`define FSR_OP_EXIT_QUAD 8'hf5

// ****************************************************
// register fields and resets
// ****************************************************
`define FSR_SR_BUSY 0
`define FSR_SR_WEL 1
`define FSR_SR_QE 6
`define FSR_SR_LOCK 7
`define FSR_CR_TB 3
`define FSR_CR_PBE 4
`define FSR_CR_WIDE 5
`define FSR_SR_NV_RESET 6'h00
`define FSR_CR_RESET 8'h07

// ****************************************************
// timing
// ****************************************************
`define FSR_CLK_NS 10
`define FSR_PROG_NS 5000
`define FSR_REGISTER_WRITE_CMD_NS 4000
`define FSR_PROG_CYC ((`FSR_PROG_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_REGISTER_WRITE_CMD_CYC ((`FSR_REGISTER_WRITE_CMD_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_HALF_SCK 12
`define FSR_HALF_SCK_MIN 10

// ****************************************************
// host controller registers (byte addresses)
// ****************************************************
`define FSR_HREG_CMD 8'h00
`define FSR_HREG_ADDR 8'h04
`define FSR_HREG_TXD 8'h08
`define FSR_HREG_STAT 8'h0c
`define FSR_HREG_WP 8'h10
`define FSR_CMD_HAS_ADDR 8
`define FSR_CMD_WIDE 9
`define FSR_CMD_QUAD 10
`define FSR_CMD_TXB_LO 12
`define FSR_CMD_RXB_LO 14
`endif

// ===== logic/fsr_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"
module fsr_device #(
   parameter int ARRAY_AW = 26,
   parameter int BLOCK_AW = 16
) (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   fsr_link_if.dev LINK,
   output logic BUSY,
   output logic QUAD_CMD_MODE,
   output logic [2:0] DRIVE_STRENGTH,
   output logic PREAMBLE_EN,
   output logic WIDE_ADDR,
   output logic PROTECT_FROM_BOTTOM,
   output logic [3:0] DUMMY_FAST,
   output logic [3:0] DUMMY_DUAL_IO,
   output logic [3:0] DUMMY_QUAD_IO
);
   generate
      if (ARRAY_AW > 32 || BLOCK_AW < 1 || BLOCK_AW >= ARRAY_AW)
      begin : g_bad
         $error("fsr_device: array and block widths do not fit");
      end
   endgenerate

   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [3:0] dummy_cycles(input logic [1:0] dc, input logic [1:0] kind);
      unique case (dc)
         2'b00: dummy_cycles = (kind == 2'd1) ? 4'h4 : (kind == 2'd2) ? 4'h6 : 4'h8;
         2'b01: dummy_cycles = (kind == 2'd2) ? 4'h4 : 4'h6;
         2'b10: dummy_cycles = 4'h8;
         2'b11: dummy_cycles = 4'ha;
      endcase
   endfunction : dummy_cycles

   // level 0 guards nothing; each step doubles the guarded span from one end
   function automatic logic protected_at(input logic [31:0] a, input logic [3:0] bp,
                                         input logic tb);
      logic [32:0] span;
      logic [32:0] top;
      span = (33'h1 << (BLOCK_AW - 1)) << bp;
      top = 33'h1 << ARRAY_AW;
      if (bp == 4'h0)
         protected_at = 1'b0;
      else if (span >= top)
         protected_at = 1'b1;
      else if (tb)
         protected_at = {1'b0, a} < span;
      else
         protected_at = {1'b0, a} >= top - span;
   endfunction : protected_at

   fsr_pkg::fsr_dev_s q_r, q_nxt;
   logic sel_fall, sel_rise, clk_rise, clk_fall, idle, qe, hardware_protect_mode;
   logic [5:0] nbit;
   logic [31:0] sh;
   logic [7:0] sr_live, byte_now;

   // ****************************************************
   // next state
   // ****************************************************
   always_comb
   begin
      q_nxt = q_r;
      q_nxt.s1 = {LINK.cs_n, LINK.sck, LINK.sio};
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      q_nxt.f = fsr_pkg::agree(q_r.s2, q_r.s3, q_r.f);
      sel_fall = q_r.f[5] & ~q_nxt.f[5];
      sel_rise = ~q_r.f[5] & q_nxt.f[5];
      clk_rise = ~q_nxt.f[5] & ~q_r.f[4] & q_nxt.f[4];
      clk_fall = ~q_nxt.f[5] & q_r.f[4] & ~q_nxt.f[4];
      idle = q_r.job == fsr_pkg::JOB_IDLE;
      qe = q_r.sr_nv[`FSR_SR_QE - 2];
      // line 2 is the protect input only while quad lines are off
      hardware_protect_mode = q_r.sr_nv[`FSR_SR_LOCK - 2] & ~q_nxt.f[2] & ~qe;
      sr_live = {q_r.sr_nv, q_r.write_enable_latch, ~idle};
      nbit = q_r.nbit + (q_r.quad_command_mode ? 6'd4 : 6'd1);
      sh = q_r.quad_command_mode ? {q_r.sh[27:0], q_nxt.f[3:0]} : {q_r.sh[30:0], q_nxt.f[0]};
      byte_now = (q_r.opos == 3'd0) ?
                 ((q_r.opc == `FSR_OP_READ_STATUS) ? sr_live : q_r.cr) : q_r.obyte;

      if (sel_fall)
      begin
         q_nxt.ph = fsr_pkg::PH_CMD;
         q_nxt.nbit = 6'd0;
         q_nxt.addr_ok = 1'b0;
         q_nxt.sio_e = 4'h0;
      end
      else if (clk_rise)
      begin
         q_nxt.sh = sh;
         q_nxt.nbit = nbit;
         unique case (q_r.ph)
            fsr_pkg::PH_CMD:
               if (nbit == 6'd8)
               begin
                  q_nxt.opc = sh[7:0];
                  q_nxt.nbit = 6'd0;
                  q_nxt.opos = 3'd0;
                  q_nxt.ph = fsr_pkg::PH_SKIP;
                  unique case (sh[7:0])
                     `FSR_OP_READ_STATUS, `FSR_OP_READ_CONFIG:
                        q_nxt.ph = fsr_pkg::PH_OUT;
                     `FSR_OP_REG_WRITE:
                        if (idle)
                           q_nxt.ph = fsr_pkg::PH_WDATA;
                     `FSR_OP_PAGE_PROG, `FSR_OP_SECTOR_ERASE, `FSR_OP_HALF_BLOCK_ERASE,
                     `FSR_OP_BLOCK_ERASE:
                        if (idle)
                           q_nxt.ph = fsr_pkg::PH_ADDR;
                     `FSR_OP_QUAD_PROG:
                        if (idle && qe)
                           q_nxt.ph = fsr_pkg::PH_ADDR;
                     default:
                        q_nxt.ph = fsr_pkg::PH_SKIP;
                  endcase
               end
            fsr_pkg::PH_ADDR:
               if (nbit == (q_r.cr[`FSR_CR_WIDE] ? 6'd32 : 6'd24))
               begin
                  q_nxt.addr = q_r.cr[`FSR_CR_WIDE] ? sh : {8'h00, sh[23:0]};
                  q_nxt.addr_ok = 1'b1;
                  q_nxt.ph = fsr_pkg::PH_SKIP;
               end
            fsr_pkg::PH_WDATA:
               if (nbit > 6'd16)
                  q_nxt.ph = fsr_pkg::PH_SKIP;
            default:
               q_nxt.nbit = q_r.nbit;
         endcase
      end
      else if (clk_fall && q_r.ph == fsr_pkg::PH_OUT)
      begin
         // the byte is refetched at each boundary so polling sees busy drop
         q_nxt.obyte = byte_now;
         if (q_r.quad_command_mode)
         begin
            q_nxt.sio_o = (q_r.opos == 3'd0) ? byte_now[7:4] : byte_now[3:0];
            q_nxt.sio_e = 4'hf;
            q_nxt.opos = q_r.opos + 3'd4;
         end
         else
         begin
            q_nxt.sio_o = {2'b00, byte_now[3'd7 - q_r.opos], 1'b0};
            q_nxt.sio_e = 4'h2;
            q_nxt.opos = q_r.opos + 3'd1;
         end
      end

      if (sel_rise)
      begin
         q_nxt.sio_e = 4'h0;
         if (idle)
            unique case (q_r.opc)
               `FSR_OP_WRITE_ENABLE:
                  q_nxt.write_enable_latch = 1'b1;
               `FSR_OP_WRITE_DISABLE:
                  q_nxt.write_enable_latch = 1'b0;
               `FSR_OP_ENTER_WIDE:
                  q_nxt.cr[`FSR_CR_WIDE] = 1'b1;
               `FSR_OP_EXIT_WIDE:
                  q_nxt.cr[`FSR_CR_WIDE] = 1'b0;
               `FSR_OP_ENTER_QUAD:
                  q_nxt.quad_command_mode = qe;
               `FSR_OP_EXIT_QUAD:
                  q_nxt.quad_command_mode = 1'b0;
               `FSR_OP_REG_WRITE:
                  if (q_r.ph == fsr_pkg::PH_WDATA && q_r.write_enable_latch && !hardware_protect_mode &&
                      (q_r.nbit == 6'd8 || q_r.nbit == 6'd16))
                  begin
                     q_nxt.job = fsr_pkg::JOB_REGISTER_WRITE_CMD;
                     q_nxt.tmr = 16'(`FSR_REGISTER_WRITE_CMD_CYC);
                     q_nxt.wval = (q_r.nbit == 6'd16) ? q_r.sh[15:0] : {q_r.sh[7:0], q_r.cr};
                  end
               `FSR_OP_PAGE_PROG, `FSR_OP_QUAD_PROG, `FSR_OP_SECTOR_ERASE,
               `FSR_OP_HALF_BLOCK_ERASE, `FSR_OP_BLOCK_ERASE:
                  if (q_r.addr_ok && q_r.write_enable_latch)
                  begin
                     if (protected_at(q_r.addr, q_r.sr_nv[3:0], q_r.cr[`FSR_CR_TB]))
                        q_nxt.write_enable_latch = 1'b0;
                     else
                     begin
                        q_nxt.job = fsr_pkg::JOB_PROG;
                        q_nxt.tmr = 16'(`FSR_PROG_CYC);
                     end
                  end
               `FSR_OP_CHIP_ERASE:
                  if (q_r.write_enable_latch && q_r.ph == fsr_pkg::PH_SKIP && q_r.nbit == 6'd0)
                  begin
                     if (q_r.sr_nv[3:0] != 4'h0)
                        q_nxt.write_enable_latch = 1'b0;
                     else
                     begin
                        q_nxt.job = fsr_pkg::JOB_PROG;
                        q_nxt.tmr = 16'(`FSR_PROG_CYC);
                     end
                  end
               default:
                  q_nxt.write_enable_latch = q_r.write_enable_latch;
            endcase
         q_nxt.opc = 8'h00;
      end

      if (!idle)
      begin
         q_nxt.tmr = q_r.tmr - 16'd1;
         if (q_r.tmr == 16'd1)
         begin
            q_nxt.job = fsr_pkg::JOB_IDLE;
            q_nxt.write_enable_latch = 1'b0;
            if (q_r.job == fsr_pkg::JOB_REGISTER_WRITE_CMD)
            begin
               q_nxt.sr_nv = q_r.wval[15:10];
               // top/bottom is one-time: it may be set but never cleared
               q_nxt.cr = {q_r.wval[7:6], q_r.cr[`FSR_CR_WIDE], q_r.wval[4],
                           q_r.cr[`FSR_CR_TB] | q_r.wval[3], q_r.wval[2:0]};
            end
         end
      end

      q_nxt.dmy_fast = dummy_cycles(q_r.cr[7:6], 2'd0);
      q_nxt.dmy_dio = dummy_cycles(q_r.cr[7:6], 2'd1);
      q_nxt.dmy_qio = dummy_cycles(q_r.cr[7:6], 2'd2);
   end

   // ****************************************************
   // state register
   // ****************************************************
   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         q_r <= '0;
         q_r.s1 <= 6'h3f;
         q_r.s2 <= 6'h2f;
         q_r.s3 <= 6'h2f;
         q_r.f <= 6'h2f;
         q_r.ph <= fsr_pkg::PH_SKIP;
         q_r.job <= fsr_pkg::JOB_IDLE;
         q_r.sr_nv <= `FSR_SR_NV_RESET;
         q_r.cr <= `FSR_CR_RESET;
         q_r.dmy_fast <= 4'h8;
         q_r.dmy_dio <= 4'h4;
         q_r.dmy_qio <= 4'h6;
      end
      else
         q_r <= q_nxt;
   end

   assign LINK.d_out = q_r.sio_o;
   assign LINK.d_oe = q_r.sio_e;
   assign BUSY = q_r.job != fsr_pkg::JOB_IDLE;
   assign QUAD_CMD_MODE = q_r.quad_command_mode;
   assign DRIVE_STRENGTH = q_r.cr[2:0];
   assign PREAMBLE_EN = q_r.cr[`FSR_CR_PBE];
   assign WIDE_ADDR = q_r.cr[`FSR_CR_WIDE];
   assign PROTECT_FROM_BOTTOM = q_r.cr[`FSR_CR_TB];
   assign DUMMY_FAST = q_r.dmy_fast;
   assign DUMMY_DUAL_IO = q_r.dmy_dio;
   assign DUMMY_QUAD_IO = q_r.dmy_qio;
endmodule : fsr_device
`default_nettype wire

// ===== logic/fsr_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"
module fsr_host #(
   parameter int HALF_SCK = `FSR_HALF_SCK
) (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   fsr_link_if.host LINK,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA
);
   generate
      if (HALF_SCK < `FSR_HALF_SCK_MIN || HALF_SCK > 255)
      begin : g_bad
         $error("fsr_host: half period too short for the device synchronisers");
      end
   endgenerate

   fsr_pkg::fsr_host_s q_r, q_nxt;
   logic [5:0] fs;
   logic tick;
   logic [5:0] step;
   logic [47:0] body;

   // ****************************************************
   // next state
   // ****************************************************
   always_comb
   begin
      q_nxt = q_r;
      q_nxt.s1 = LINK.sio;
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      fs = fsr_pkg::agree({2'b00, q_r.s2}, {2'b00, q_r.s3}, {2'b00, q_r.f});
      q_nxt.f = fs[3:0];
      tick = q_r.div == 8'(HALF_SCK - 1);
      step = q_r.quad ? 6'd4 : 6'd1;
      body = WDATA[`FSR_CMD_HAS_ADDR] ?
             (WDATA[`FSR_CMD_WIDE] ? {q_r.addr, q_r.txd} : {q_r.addr[23:0], q_r.txd, 8'h00}) :
             {q_r.txd, 32'h0};
      q_nxt.rdata = 32'h0;

      if (WR)
         unique case (ADDR)
            `FSR_HREG_ADDR:
               q_nxt.addr = WDATA;
            `FSR_HREG_TXD:
               q_nxt.txd = WDATA[15:0];
            `FSR_HREG_WP:
               q_nxt.wp = WDATA[0];
            default:
               q_nxt.wp = q_r.wp;
         endcase
      if (RD)
         unique case (ADDR)
            `FSR_HREG_CMD, `FSR_HREG_STAT:
               q_nxt.rdata = {q_r.rx, 7'h00, q_r.st != fsr_pkg::HS_IDLE};
            `FSR_HREG_ADDR:
               q_nxt.rdata = q_r.addr;
            `FSR_HREG_TXD:
               q_nxt.rdata = {16'h0, q_r.txd};
            `FSR_HREG_WP:
               q_nxt.rdata = {31'h0, q_r.wp};
            default:
               q_nxt.rdata = 32'h0;
         endcase

      q_nxt.div = tick ? 8'h00 : q_r.div + 8'h01;
      unique case (q_r.st)
         fsr_pkg::HS_IDLE:
         begin
            q_nxt.sio_e = 4'h4;
            q_nxt.sio_o = {1'b1, q_nxt.wp, 2'b00};
            // the frame opens by pulling select low with the first bits set up
            if (WR && ADDR == `FSR_HREG_CMD)
            begin
               q_nxt.st = fsr_pkg::HS_RUN;
               q_nxt.cs_n = 1'b0;
               q_nxt.div = 8'h00;
               q_nxt.quad = WDATA[`FSR_CMD_QUAD];
               q_nxt.tx = {WDATA[7:0], body};
               q_nxt.txl = 6'd8 + (WDATA[`FSR_CMD_HAS_ADDR] ?
                           (WDATA[`FSR_CMD_WIDE] ? 6'd32 : 6'd24) : 6'd0) +
                           {1'b0, WDATA[`FSR_CMD_TXB_LO +: 2], 3'b000};
               q_nxt.rxl = {1'b0, WDATA[`FSR_CMD_RXB_LO +: 2], 3'b000};
               q_nxt.rx = 24'h0;
               if (WDATA[`FSR_CMD_QUAD])
               begin
                  q_nxt.sio_o = WDATA[7:4];
                  q_nxt.sio_e = 4'hf;
               end
               else
               begin
                  // line 2 carries the protect level outside quad frames
                  q_nxt.sio_o = {1'b1, q_nxt.wp, 1'b0, WDATA[7]};
                  q_nxt.sio_e = 4'h5;
               end
            end
         end
         fsr_pkg::HS_RUN:
            if (tick)
            begin
               q_nxt.sck = ~q_r.sck;
               if (!q_r.sck)
               begin
                  if (q_r.txl != 6'd0)
                     q_nxt.txl = q_r.txl - step;
                  else if (q_r.rxl != 6'd0)
                  begin
                     q_nxt.rx = q_r.quad ? {q_r.rx[19:0], q_r.f} : {q_r.rx[22:0], q_r.f[1]};
                     q_nxt.rxl = q_r.rxl - step;
                  end
               end
               else if (q_r.txl == 6'd0 && q_r.rxl == 6'd0)
                  q_nxt.st = fsr_pkg::HS_END;
               else if (q_r.txl != 6'd0)
               begin
                  q_nxt.tx = q_r.quad ? {q_r.tx[51:0], 4'h0} : {q_r.tx[54:0], 1'b0};
                  q_nxt.sio_o = q_r.quad ? q_r.tx[51:48] : {1'b1, q_r.wp, 1'b0, q_r.tx[54]};
               end
               else
                  // read phase: let the device own the data lines
                  q_nxt.sio_e = q_r.quad ? 4'h0 : 4'h4;
            end
         fsr_pkg::HS_END:
            if (tick)
            begin
               // select stays high one half period before the next frame may start;
               // line 2 is taken back only then, once the device has let go after quad reads
               if (q_r.cs_n)
               begin
                  q_nxt.st = fsr_pkg::HS_IDLE;
                  q_nxt.sio_e = 4'h4;
                  q_nxt.sio_o = {1'b1, q_r.wp, 2'b00};
               end
               q_nxt.cs_n = 1'b1;
            end
      endcase
   end

   // ****************************************************
   // state register
   // ****************************************************
   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         q_r <= '0;
         q_r.s1 <= 4'hf;
         q_r.s2 <= 4'hf;
         q_r.s3 <= 4'hf;
         q_r.f <= 4'hf;
         q_r.st <= fsr_pkg::HS_IDLE;
         q_r.cs_n <= 1'b1;
         q_r.wp <= 1'b1;
         q_r.sio_o <= 4'hc;
         q_r.sio_e <= 4'h4;
      end
      else
         q_r <= q_nxt;
   end

   assign LINK.cs_n = q_r.cs_n;
   assign LINK.sck = q_r.sck;
   assign LINK.h_out = q_r.sio_o;
   assign LINK.h_oe = q_r.sio_e;
   assign RDATA = q_r.rdata;
endmodule : fsr_host
`default_nettype wire

// ===== logic/fsr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsr_link_if;
   logic cs_n;
   logic sck;
   logic [3:0] h_out, h_oe, d_out, d_oe;
   logic [3:0] sio;
   // device wins where both drive; undriven lines float high through a pull-up
   assign sio = (d_oe & d_out) | (~d_oe & h_oe & h_out) | (~d_oe & ~h_oe);
   modport dev (input cs_n, input sck, input sio, output d_out, output d_oe);
   modport host (output cs_n, output sck, output h_out, output h_oe, input sio);
endinterface : fsr_link_if
`default_nettype wire

// ===== logic/fsr_pkg.sv
`default_nettype none
package fsr_pkg;
   typedef enum logic [4:0] {
      PH_CMD = 5'b00001,
      PH_ADDR = 5'b00010,
      PH_WDATA = 5'b00100,
      PH_OUT = 5'b01000,
      PH_SKIP = 5'b10000
   } fsr_phase_e;
   typedef enum logic [2:0] {
      JOB_IDLE = 3'b001,
      JOB_PROG = 3'b010,
      JOB_REGISTER_WRITE_CMD = 3'b100
   } fsr_job_e;
   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_RUN = 3'b010,
      HS_END = 3'b100
   } fsr_hstate_e;
   typedef struct packed {
      logic [5:0] s1, s2, s3, f;
      fsr_phase_e ph;
      fsr_job_e job;
      logic quad_command_mode;
      logic [5:0] nbit;
      logic [7:0] opc;
      logic [31:0] sh;
      logic [31:0] addr;
      logic addr_ok;
      logic [7:0] obyte;
      logic [2:0] opos;
      logic [3:0] sio_o, sio_e;
      logic [5:0] sr_nv;
      logic write_enable_latch;
      logic [7:0] cr;
      logic [15:0] tmr;
      logic [15:0] wval;
      logic [3:0] dmy_fast, dmy_dio, dmy_qio;
   } fsr_dev_s;
   typedef struct packed {
      logic [3:0] s1, s2, s3, f;
      fsr_hstate_e st;
      logic [7:0] div;
      logic sck, cs_n, quad;
      logic [55:0] tx;
      logic [5:0] txl, rxl;
      logic [23:0] rx;
      logic [3:0] sio_o, sio_e;
      logic [31:0] addr;
      logic [15:0] txd;
      logic wp;
      logic [31:0] rdata;
   } fsr_host_s;

   // a bit follows the sampled pin only once the last two stages agree
   function automatic logic [5:0] agree(input logic [5:0] a, input logic [5:0] b,
                                        input logic [5:0] f);
      agree = ((a ~^ b) & b) | ((a ^ b) & f);
   endfunction : agree
endpackage : fsr_pkg
`default_nettype wire

// ===== test/flash_status_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin fails++; $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module flash_status_config_regs_tb_top;
   logic SYS_CLK = 1'b0;
   logic RST_B = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic [31:0] RDATA, st;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic q = 1'b0;
   logic BUSY, QUAD_CMD_MODE, PREAMBLE_EN, WIDE_ADDR, PROTECT_FROM_BOTTOM;
   logic [2:0] DRIVE_STRENGTH;
   logic [3:0] DUMMY_FAST, DUMMY_DUAL_IO, DUMMY_QUAD_IO;
   logic [7:0] s, c, b;
   // program and erase opcodes aimed at the guarded area
   logic [39:0] ops = 40'h02_38_20_52_d8;
   int fails = 0;
   int tests_run = 0;
   // ****************************************************
   // ends, link and checker
   // ****************************************************
   always #5 SYS_CLK = ~SYS_CLK;
   fsr_link_if fsr_link_if_i ();
   fsr_device fsr_device_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .LINK(fsr_link_if_i),
      .BUSY(BUSY), .QUAD_CMD_MODE(QUAD_CMD_MODE), .DRIVE_STRENGTH(DRIVE_STRENGTH),
      .PREAMBLE_EN(PREAMBLE_EN), .WIDE_ADDR(WIDE_ADDR), .PROTECT_FROM_BOTTOM(PROTECT_FROM_BOTTOM),
      .DUMMY_FAST(DUMMY_FAST), .DUMMY_DUAL_IO(DUMMY_DUAL_IO), .DUMMY_QUAD_IO(DUMMY_QUAD_IO));
   fsr_host fsr_host_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .LINK(fsr_link_if_i), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
   fsr_link_asserts fsr_link_asserts_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
      .cs_n(fsr_link_if_i.cs_n), .sck(fsr_link_if_i.sck), .h_out(fsr_link_if_i.h_out),
      .h_oe(fsr_link_if_i.h_oe), .d_out(fsr_link_if_i.d_out), .d_oe(fsr_link_if_i.d_oe));
   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [11:0] dmy(input logic [1:0] dc);
      case (dc)
         2'b00: dmy = {4'h8, 4'h4, 4'h6};
         2'b01: dmy = {4'h6, 4'h6, 4'h4};
         2'b10: dmy = {4'h8, 4'h8, 4'h8};
         default: dmy = {4'ha, 4'ha, 4'ha};
      endcase
   endfunction : dmy
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask : rd
   // every frame goes out on quad lines once quad mode is on
   task automatic cmd(input logic [15:0] w, output logic [31:0] r);
      int i;
      wr(8'h00, {16'h0, w | {5'h0, q, 10'h0}});
      for (i = 0; i < 1000; i++)
      begin
         rd(8'h0c, r);
         if (r[0] === 1'b0)
            break;
      end
      if (i == 1000)
      begin
         fails++;
         complete_run();
      end
   endtask : cmd
   // two bytes read back so the repeat of the byte is checked every time
   task automatic rr(input logic [7:0] op, output logic [7:0] v);
      logic [31:0] r;
      cmd({8'h80, op}, r);
      `CHK("repeat", r[23:16], r[15:8])
      v = r[15:8];
   endtask : rr
   // ****************************************************
   // main sequence
   // ****************************************************
   initial
   begin
      void'($urandom(19));
      repeat (5) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      rr(8'h05, b);
      `CHK("status", 8'h00, b)
      rr(8'h15, b);
      `CHK("config", 8'h07, b)
      `CHK("dummy", dmy(2'b00), {DUMMY_FAST, DUMMY_DUAL_IO, DUMMY_QUAD_IO})
      cmd(16'h0102, st);
      rr(8'h05, b);
      `CHK("no latch", 8'h00, b)
      cmd(16'h0006, st);
      rr(8'h05, b);
      `CHK("latch", 8'h02, b)
      cmd(16'h0004, st);
      rr(8'h05, b);
      `CHK("unlatch", 8'h00, b)
      cmd(16'h0006, st);
      cmd(16'h0035, st);
      `CHK("no quad", 1'b0, QUAD_CMD_MODE)
      // quad enable is always written so that quad frames get exercised below
      s = {1'b0, 1'b1, 4'($urandom_range(15, 1)), 2'b00};
      c = 8'($urandom) | 8'h08;
      wr(8'h08, {16'h0, s, c});
      cmd(16'h2001, st);
      `CHK("busy pin", 1'b1, BUSY)
      cmd(16'h4005, st);
      `CHK("busy", 8'h03, st[15:8])
      for (int k = 0; k < 8; k++)
      begin
         rr(8'h05, b);
         if (b[0] === 1'b0)
            break;
      end
      `CHK("status", s, b)
      `CHK("idle pin", 1'b0, BUSY)
      rr(8'h15, b);
      `CHK("config", c & 8'hdf, b)
      `CHK("pins", c[4:0], {PREAMBLE_EN, PROTECT_FROM_BOTTOM, DRIVE_STRENGTH})
      `CHK("dummy", dmy(c[7:6]), {DUMMY_FAST, DUMMY_DUAL_IO, DUMMY_QUAD_IO})
      cmd(16'h0035, st);
      q = s[6];
      `CHK("quad", s[6], QUAD_CMD_MODE)
      cmd(16'h00b7, st);
      rr(8'h15, b);
      `CHK("wide", 2'b11, {b[5], WIDE_ADDR})
      cmd(16'h00e9, st);
      rr(8'h15, b);
      `CHK("narrow", 2'b00, {b[5], WIDE_ADDR})
      // nonzero level: chip erase refused, bottom program hits guarded area
      cmd(16'h0006, st);
      cmd(16'h00c7, st);
      rr(8'h05, b);
      `CHK("erase", s, b)
      wr(8'h04, 32'h0);
      for (int k = 0; k < 5; k++)
      begin
         cmd(16'h0006, st);
         cmd({8'h01, ops[8 * k +: 8]}, st);
         rr(8'h05, b);
         `CHK("guarded", s, b)
      end
      cmd(16'h00f5, st);
      q = 1'b0;
      `CHK("single", 1'b0, QUAD_CMD_MODE)
      rr(8'h05, b);
      `CHK("status", s, b)
      complete_run();
   end
endmodule : flash_status_config_regs_tb_top
`default_nettype wire

// ===== test/fsr_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_link_asserts (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] h_out,
   input wire logic [3:0] h_oe,
   input wire logic [3:0] d_out,
   input wire logic [3:0] d_oe
);
   // ****************************************************
   // link checks
   // ****************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   idle_clock_low_a: assert property (cs_n |-> !sck)
      else $error("serial clock high while deselected");
   half_period_a: assert property ($changed(sck) |=> $stable(sck) [*8])
      else $error("serial clock half period too short");
   deselect_gap_a: assert property ($rose(cs_n) |=> cs_n [*4])
      else $error("select gap too short");
   release_after_a: assert property (cs_n [*8] |-> d_oe == 4'h0)
      else $error("device still drives after deselect");
   no_contention_a: assert property ((d_oe & h_oe) == 4'h0)
      else $error("both ends drive one line");
   line_choice_a: assert property (d_oe != 4'h0 |-> d_oe == 4'h2 || d_oe == 4'hf)
      else $error("device drives wrong lines");
   out_on_low_a: assert property (d_oe != 4'h0 && $past(d_oe) != 4'h0 && $changed(d_out)
      |-> !sck)
      else $error("device data changed with clock high");
   host_hold_a: assert property ($rose(sck) |-> $stable(h_out))
      else $error("host data changed at clock rise");
endmodule : fsr_link_asserts
`default_nettype wire
